// *** design/pntc_core.sv ***
// network control core: addressing, retransmission, hop sync, tdma polling, relaying
//
// Contract
// - destination 65535 means broadcast to all
// - send once plus retry count extra copies; tdma polling holds extras back, a new send drops unsent ones
// - lose sync after timeout hops without sync
// - sync only to matching network id, type
// - master polls slave list in order
// - wait allocation timeout hops for completion
// - re-poll silent slave each hop until timeout
// - 8192 entries reset to index plus two
// - zero entry ends list, restart at zero
// - host writes, reads and dumps list entries
// - grant mode 1 enables tdma polling
// - topology 2 and variant 2 select relaying
// - master rebroadcasts slave data; slaves filter address
// - everyone mode relays broadcast through master
// - master owns unit address one
`timescale 1ns/1ps
module pntc_core
#(
    parameter int HOP_LEN = pntc_pkg::HOP_CYCLES        // cycles per hop, shorten in simulation
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic cmd_valid,                         // host command strobe
    input wire pntc_pkg::pntc_cmd_t cmd,
    output logic cmd_ready,                             // low while list init or dump runs
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    output logic rsp_last,
    input wire logic rx_valid,                          // one frame from the radio link
    input wire pntc_pkg::pntc_frame_t rx_frame,
    output logic tx_valid,
    output pntc_pkg::pntc_frame_t tx_frame,
    output logic tx_bcast,
    output logic dlv_valid,                             // data accepted for the host
    output logic [15:0] dlv_data,
    output logic synced,
    output logic hop_strobe
);
    import pntc_pkg::*;

    // =========================================================
    // state
    typedef struct packed {
        logic [31:0] hop_cnt;                           // local hop divider
        logic hop;
        logic [15:0] own_addr;
        logic [15:0] dest_addr;
        logic [7:0] retry;
        logic [15:0] sync_to;
        logic [15:0] net_id;
        logic [7:0] net_type;
        logic [7:0] grant;
        logic [15:0] poll_to;
        logic [7:0] variant;
        logic synced;
        logic [15:0] sync_cnt;                          // hops since last sync
        pntc_poll_t pstate;
        logic [12:0] pidx;                              // current list entry
        logic [15:0] wait_cnt;                          // hops spent on current entry
        logic [15:0] pollee;
        logic [7:0] retx_left;                          // extra copies still owed
        logic [15:0] retx_data;
        logic relay_pend;
        pntc_frame_t relay_frame;
        logic init_act;
        logic [13:0] init_idx;
        logic dump_act;
        logic [12:0] dump_idx;
        logic cmd_ready;
        logic rsp_valid;
        logic [15:0] rsp_data;
        logic rsp_last;
        logic tx_valid;
        pntc_frame_t tx_frame;
        logic tx_bcast;
        logic dlv_valid;
        logic [15:0] dlv_data;
    } pntc_state_t;

    pntc_state_t st_ff;
    pntc_state_t nxt_st;
    logic [15:0] slave_list [LIST_DEPTH];               // registered slave list, no reset
    logic mem_we;
    logic [12:0] mem_wa;
    logic [15:0] mem_wd;
    logic is_master;
    logic relay_mode;
    logic net_match;
    logic [12:0] tgt_idx;
    logic [12:0] nxt_idx;
    logic expired;
    logic relay_set;                                    // a frame to relay arrives this cycle

    assign is_master = (st_ff.own_addr == MASTER_ADDR);
    assign relay_mode = (st_ff.net_type == TOPO_RELAY) && (st_ff.variant == VARIANT_RELAY);
    assign net_match = (rx_frame.net_id == st_ff.net_id) && (rx_frame.net_type == st_ff.net_type);
    assign nxt_idx = st_ff.pidx + 13'h1;
    assign expired = (st_ff.wait_cnt + 16'h1) >= st_ff.poll_to;
    assign relay_set = rx_valid && net_match && rx_frame.kind == K_DATA && is_master && relay_mode;

    // poll target for this hop: a zero entry wraps back to the head
    always_comb
    begin
        tgt_idx = (st_ff.pstate == P_WAIT && expired) ? nxt_idx : st_ff.pidx;
        if (slave_list[tgt_idx] == LIST_END)
        begin
            tgt_idx = 13'h0;
        end
    end

    // =========================================================
    // next-state logic
    always_comb
    begin
        nxt_st = st_ff;
        mem_we = 1'b0;
        mem_wa = 13'h0;
        mem_wd = 16'h0;
        nxt_st.rsp_valid = 1'b0;
        nxt_st.rsp_last = 1'b0;
        nxt_st.tx_valid = 1'b0;
        nxt_st.dlv_valid = 1'b0;
        // single hop strobe from the local clock
        nxt_st.hop = 1'b0;
        if (st_ff.hop_cnt >= HOP_LEN - 1)
        begin
            nxt_st.hop_cnt = 32'h0;
            nxt_st.hop = 1'b1;
        end
        else
        begin
            nxt_st.hop_cnt = st_ff.hop_cnt + 32'h1;
        end
        // list fill after reset, one entry per cycle
        if (st_ff.init_act)
        begin
            mem_we = 1'b1;
            mem_wa = st_ff.init_idx[12:0];
            mem_wd = {3'h0, st_ff.init_idx[12:0]} + LIST_RST_OFS;
            nxt_st.init_idx = st_ff.init_idx + 14'h1;
            nxt_st.init_act = (st_ff.init_idx != 14'(LIST_DEPTH - 1));
        end
        else if (st_ff.dump_act)
        begin
            // dump streams every entry, last flagged
            nxt_st.rsp_valid = 1'b1;
            nxt_st.rsp_data = slave_list[st_ff.dump_idx];
            nxt_st.rsp_last = (st_ff.dump_idx == 13'h1FFF);
            nxt_st.dump_idx = st_ff.dump_idx + 13'h1;
            nxt_st.dump_act = (st_ff.dump_idx != 13'h1FFF);
        end
        else if (cmd_valid && st_ff.cmd_ready)
        begin
            case (cmd.op)
                OP_WR_REG:
                begin
                    // out-of-range limits are clamped, not refused
                    if (cmd.sel[3:0] == SEL_OWN_ADDR) nxt_st.own_addr = cmd.data;
                    else if (cmd.sel[3:0] == SEL_DEST_ADDR) nxt_st.dest_addr = cmd.data;
                    else if (cmd.sel[3:0] == SEL_RETRY)
                        nxt_st.retry = (cmd.data > 16'(MAX_RETRY)) ? MAX_RETRY : cmd.data[7:0];
                    else if (cmd.sel[3:0] == SEL_SYNC_TO)
                        nxt_st.sync_to = (cmd.data < MIN_SYNC_TO) ? MIN_SYNC_TO :
                                         (cmd.data > MAX_SYNC_TO) ? MAX_SYNC_TO : cmd.data;
                    else if (cmd.sel[3:0] == SEL_NET_ID) nxt_st.net_id = cmd.data;
                    else if (cmd.sel[3:0] == SEL_NET_TYPE) nxt_st.net_type = cmd.data[7:0];
                    else if (cmd.sel[3:0] == SEL_GRANT) nxt_st.grant = cmd.data[7:0];
                    else if (cmd.sel[3:0] == SEL_POLL_TO) nxt_st.poll_to = cmd.data;
                    else if (cmd.sel[3:0] == SEL_VARIANT) nxt_st.variant = cmd.data[7:0];
                end
                OP_RD_REG:
                begin
                    nxt_st.rsp_valid = 1'b1;
                    nxt_st.rsp_last = 1'b1;
                    if (cmd.sel[3:0] == SEL_OWN_ADDR) nxt_st.rsp_data = st_ff.own_addr;
                    else if (cmd.sel[3:0] == SEL_DEST_ADDR) nxt_st.rsp_data = st_ff.dest_addr;
                    else if (cmd.sel[3:0] == SEL_RETRY) nxt_st.rsp_data = {8'h0, st_ff.retry};
                    else if (cmd.sel[3:0] == SEL_SYNC_TO) nxt_st.rsp_data = st_ff.sync_to;
                    else if (cmd.sel[3:0] == SEL_NET_ID) nxt_st.rsp_data = st_ff.net_id;
                    else if (cmd.sel[3:0] == SEL_NET_TYPE) nxt_st.rsp_data = {8'h0, st_ff.net_type};
                    else if (cmd.sel[3:0] == SEL_GRANT) nxt_st.rsp_data = {8'h0, st_ff.grant};
                    else if (cmd.sel[3:0] == SEL_POLL_TO) nxt_st.rsp_data = st_ff.poll_to;
                    else if (cmd.sel[3:0] == SEL_VARIANT) nxt_st.rsp_data = {8'h0, st_ff.variant};
                    else if (cmd.sel[3:0] == SEL_STATUS) nxt_st.rsp_data = {2'h0, st_ff.synced, st_ff.pidx};
                    else nxt_st.rsp_data = 16'h0;
                end
                OP_LIST_WR:
                begin
                    // 65535 is not a legal entry and is dropped
                    mem_we = (cmd.data <= MAX_UNIT);
                    mem_wa = cmd.sel;
                    mem_wd = cmd.data;
                end
                OP_LIST_RD:
                begin
                    nxt_st.rsp_valid = 1'b1;
                    nxt_st.rsp_last = 1'b1;
                    nxt_st.rsp_data = slave_list[cmd.sel];
                end
                OP_LIST_DUMP:
                begin
                    nxt_st.dump_act = 1'b1;
                    nxt_st.dump_idx = 13'h0;
                end
                default:
                begin
                    // first copy leaves at once, extras one per hop
                    nxt_st.tx_valid = 1'b1;
                    nxt_st.tx_frame = '{src: st_ff.own_addr, dst: st_ff.dest_addr, net_id: st_ff.net_id,
                                        net_type: st_ff.net_type, kind: K_DATA, data: cmd.data};
                    nxt_st.tx_bcast = (st_ff.dest_addr == BCAST_ADDR);
                    nxt_st.retx_left = st_ff.retry;
                    nxt_st.retx_data = cmd.data;
                end
            endcase
        end
        nxt_st.cmd_ready = !nxt_st.init_act && !nxt_st.dump_act && !nxt_st.tx_valid;
        // ---- sync keeping on the hop strobe; a sync frame wins the same cycle
        if (is_master)
        begin
            nxt_st.synced = 1'b1;
            nxt_st.sync_cnt = 16'h0;
        end
        else if (rx_valid && rx_frame.kind == K_SYNC && net_match)
        begin
            nxt_st.synced = 1'b1;
            nxt_st.sync_cnt = 16'h0;
        end
        else if (st_ff.hop && st_ff.synced)
        begin
            if (st_ff.sync_cnt + 16'h1 >= st_ff.sync_to)
            begin
                nxt_st.synced = 1'b0;
                nxt_st.sync_cnt = 16'h0;
            end
            else
            begin
                nxt_st.sync_cnt = st_ff.sync_cnt + 16'h1;
            end
        end
        // ---- received frames
        if (rx_valid && net_match && rx_frame.kind == K_DATA)
        begin
            if (is_master && relay_mode)
            begin
                // slave data goes back out to every slave
                nxt_st.relay_pend = 1'b1;
                nxt_st.relay_frame = rx_frame;
            end
            if (rx_frame.dst == st_ff.own_addr || rx_frame.dst == BCAST_ADDR)
            begin
                nxt_st.dlv_valid = 1'b1;
                nxt_st.dlv_data = rx_frame.data;
            end
        end
        // ---- tdma sequencer, master only
        if (!(is_master && st_ff.grant == GRANT_TDMA) || st_ff.init_act)
        begin
            nxt_st.pstate = P_IDLE;
            nxt_st.pidx = 13'h0;
            nxt_st.wait_cnt = 16'h0;
        end
        else if (st_ff.pstate == P_WAIT && rx_valid && rx_frame.src == st_ff.pollee &&
                 (rx_frame.kind == K_DONE || rx_frame.kind == K_NODATA))
        begin
            nxt_st.pstate = P_IDLE;
            nxt_st.pidx = nxt_idx;
            nxt_st.wait_cnt = 16'h0;
        end
        else if (st_ff.hop)
        begin
            // poll (or re-poll) the target entry on this hop
            nxt_st.tx_valid = 1'b1;
            nxt_st.tx_frame = '{src: st_ff.own_addr, dst: slave_list[tgt_idx], net_id: st_ff.net_id,
                                net_type: st_ff.net_type, kind: K_POLL, data: 16'h0};
            nxt_st.tx_bcast = 1'b0;
            nxt_st.pollee = slave_list[tgt_idx];
            nxt_st.pidx = tgt_idx;
            nxt_st.pstate = P_WAIT;
            nxt_st.wait_cnt = (st_ff.pstate == P_WAIT && !expired) ? st_ff.wait_cnt + 16'h1 : 16'h0;
        end
        // ---- lower priority senders take free slots
        if (!nxt_st.tx_valid && st_ff.hop && st_ff.retx_left != 8'h0)
        begin
            nxt_st.tx_valid = 1'b1;
            nxt_st.tx_frame = '{src: st_ff.own_addr, dst: st_ff.dest_addr, net_id: st_ff.net_id,
                                net_type: st_ff.net_type, kind: K_DATA, data: st_ff.retx_data};
            nxt_st.tx_bcast = (st_ff.dest_addr == BCAST_ADDR);
            nxt_st.retx_left = st_ff.retx_left - 8'h1;
        end
        else if (!nxt_st.tx_valid && st_ff.relay_pend)
        begin
            nxt_st.tx_valid = 1'b1;
            nxt_st.tx_frame = st_ff.relay_frame;
            nxt_st.tx_frame.src = st_ff.own_addr;
            nxt_st.tx_bcast = 1'b1;
            nxt_st.relay_pend = relay_set;                           // a newer frame must not be lost
        end
        // a send taken in a polling hop would lose its first copy to the poll
        nxt_st.cmd_ready = nxt_st.cmd_ready && !nxt_st.tx_valid &&
                           !(nxt_st.hop && nxt_st.own_addr == MASTER_ADDR && nxt_st.grant == GRANT_TDMA);
    end

    // =========================================================
    // registers
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= '0;
            st_ff.own_addr <= RST_OWN_ADDR;
            st_ff.dest_addr <= RST_DEST_ADDR;
            st_ff.retry <= RST_RETRY;
            st_ff.sync_to <= RST_SYNC_TO;
            st_ff.net_id <= RST_NET_ID;
            st_ff.net_type <= RST_NET_TYPE;
            st_ff.grant <= RST_GRANT;
            st_ff.poll_to <= RST_POLL_TO;
            st_ff.variant <= RST_VARIANT;
            st_ff.init_act <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // list storage; written by init sweep or host
    always_ff @(posedge mclk)
    begin
        if (mem_we)
        begin
            slave_list[mem_wa] <= mem_wd;
        end
    end

    assign cmd_ready = st_ff.cmd_ready;
    assign rsp_valid = st_ff.rsp_valid;
    assign rsp_data = st_ff.rsp_data;
    assign rsp_last = st_ff.rsp_last;
    assign tx_valid = st_ff.tx_valid;
    assign tx_frame = st_ff.tx_frame;
    assign tx_bcast = st_ff.tx_bcast;
    assign dlv_valid = st_ff.dlv_valid;
    assign dlv_data = st_ff.dlv_data;
    assign synced = st_ff.synced;
    assign hop_strobe = st_ff.hop;

    // =========================================================
    // checks
    a_bcast_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        tx_valid && tx_frame.kind == K_DATA
        |-> tx_bcast == (tx_frame.dst == BCAST_ADDR) || (tx_bcast && is_master && relay_mode))
        else $error("broadcast flag disagrees with destination");
    a_retry_range: assert property (@(posedge mclk) disable iff (!rst_n) st_ff.retry <= MAX_RETRY)
        else $error("retry count above limit");
    a_sync_loss: assert property (@(posedge mclk) disable iff (!rst_n)
        st_ff.hop && st_ff.synced && !is_master && !rx_valid && st_ff.sync_cnt + 16'h1 >= st_ff.sync_to
        |=> !synced)
        else $error("sync not dropped at timeout");
    a_sync_match: assert property (@(posedge mclk) disable iff (!rst_n)
        !synced ##1 synced && !is_master |-> $past(rx_valid) && $past(net_match))
        else $error("sync gained from foreign network");
    a_poll_wait: assert property (@(posedge mclk) disable iff (!rst_n)
        st_ff.pstate == P_WAIT |-> st_ff.wait_cnt < st_ff.poll_to || st_ff.poll_to == 16'h0)
        else $error("poll wait beyond allocation timeout");
    a_poll_tdma: assert property (@(posedge mclk) disable iff (!rst_n)
        tx_valid && tx_frame.kind == K_POLL |-> $past(is_master) && $past(st_ff.grant) == GRANT_TDMA)
        else $error("poll issued outside tdma master");
    a_poll_nonzero: assert property (@(posedge mclk) disable iff (!rst_n)
        tx_valid && tx_frame.kind == K_POLL |-> tx_frame.dst != LIST_END || st_ff.pidx == 13'h0)
        else $error("list end polled");
    a_deliver_addr: assert property (@(posedge mclk) disable iff (!rst_n)
        dlv_valid |-> $past(rx_frame.dst) == $past(st_ff.own_addr) || $past(rx_frame.dst) == BCAST_ADDR)
        else $error("data kept for another unit");
    a_hop_period: assert property (@(posedge mclk) disable iff (!rst_n)
        hop_strobe |=> !hop_strobe)
        else $error("hop strobe longer than one cycle");
endmodule // pntc_core

// *** design/pntc_pkg.sv ***
// shared constants, encodings and carrier types for the network control block
package pntc_pkg;
    // =========================================================
    // addressing
    localparam logic [15:0] BCAST_ADDR = 16'hFFFF;     // accepted by every unit
    localparam logic [15:0] MASTER_ADDR = 16'h0001;    // fixed master address
    localparam logic [15:0] LIST_END = 16'h0000;       // terminates the slave list
    localparam logic [15:0] MAX_UNIT = 16'hFFFE;       // top legal list address
    localparam logic [15:0] LIST_RST_OFS = 16'h0002;   // entry resets to index plus this
    localparam int LIST_DEPTH = 8192;
    localparam int LIST_AW = 13;
    // =========================================================
    // register selects on the command port
    localparam logic [3:0] SEL_OWN_ADDR = 4'h0;
    localparam logic [3:0] SEL_DEST_ADDR = 4'h1;
    localparam logic [3:0] SEL_RETRY = 4'h2;
    localparam logic [3:0] SEL_SYNC_TO = 4'h3;
    localparam logic [3:0] SEL_NET_ID = 4'h4;
    localparam logic [3:0] SEL_NET_TYPE = 4'h5;
    localparam logic [3:0] SEL_GRANT = 4'h6;
    localparam logic [3:0] SEL_POLL_TO = 4'h7;
    localparam logic [3:0] SEL_VARIANT = 4'h8;
    localparam logic [3:0] SEL_STATUS = 4'h9;
    // =========================================================
    // reset values and limits
    localparam logic [15:0] RST_OWN_ADDR = 16'h0002;
    localparam logic [15:0] RST_DEST_ADDR = 16'h0001;
    localparam logic [7:0] RST_RETRY = 8'h05;
    localparam logic [7:0] MAX_RETRY = 8'hFE;
    localparam logic [15:0] RST_SYNC_TO = 16'h0064;
    localparam logic [15:0] MIN_SYNC_TO = 16'h0004;
    localparam logic [15:0] MAX_SYNC_TO = 16'hFFFE;
    localparam logic [15:0] RST_POLL_TO = 16'h000A;
    localparam logic [15:0] RST_NET_ID = 16'h0000;
    localparam logic [7:0] RST_NET_TYPE = 8'h00;
    localparam logic [7:0] RST_GRANT = 8'h00;
    localparam logic [7:0] RST_VARIANT = 8'h02;
    localparam logic [7:0] GRANT_TDMA = 8'h01;         // polling grant mode
    localparam logic [7:0] TOPO_RELAY = 8'h02;         // relayed peer topologies
    localparam logic [7:0] VARIANT_RELAY = 8'h02;
    // =========================================================
    // hop timing
    localparam int CLK_MHZ = 250;
    localparam int HOP_TIME_NS = 20000;                // hop interval, plain default
    localparam int HOP_CYCLES = HOP_TIME_NS * CLK_MHZ / 1000;
    // =========================================================
    // types
    typedef enum logic [2:0] {K_DATA, K_SYNC, K_POLL, K_DONE, K_NODATA} pntc_kind_t;
    typedef enum logic [2:0] {OP_WR_REG, OP_RD_REG, OP_LIST_WR, OP_LIST_RD, OP_LIST_DUMP, OP_SEND}
        pntc_op_t;
    typedef enum logic [0:0] {P_IDLE, P_WAIT} pntc_poll_t;
    typedef struct packed {
        logic [15:0] src;
        logic [15:0] dst;
        logic [15:0] net_id;
        logic [7:0] net_type;
        pntc_kind_t kind;
        logic [15:0] data;
    } pntc_frame_t;
    typedef struct packed {
        pntc_op_t op;
        logic [12:0] sel;
        logic [15:0] data;
    } pntc_cmd_t;
endpackage

// *** test/pntc_far_end.sv ***
// far-end remote modems that answer the master's polls over the link
`timescale 1ns/1ps
module pntc_far_end
(
    input wire logic mclk,
    input wire logic tx_valid,
    input wire pntc_pkg::pntc_frame_t tx_frame,
    input wire logic inj_valid,                    // bench-made frame, passed straight on
    input wire pntc_pkg::pntc_frame_t inj_frame,
    output logic rx_valid,
    output pntc_pkg::pntc_frame_t rx_frame
);
    import pntc_pkg::*;
    // ==========================================================
    // reply pipe: a remote answers two cycles after its poll
    logic [1:0] dly_ff = 2'h0;
    pntc_frame_t rep_ff = '0;
    pntc_frame_t last_ff = '0;                     // kept only to scramble the idle bus
    // unit 15 is powered off and never answers; 7 has nothing to send
    always_ff @(posedge mclk)
    begin
        dly_ff <= {dly_ff[0], 1'b0};
        if (tx_valid && tx_frame.kind == K_POLL && tx_frame.dst != 16'h000F)
        begin
            dly_ff[0] <= 1'b1;
            rep_ff <= '{src: tx_frame.dst, dst: MASTER_ADDR, net_id: 16'h0000, net_type: 8'h00,
                kind: (tx_frame.dst == 16'h0007) ? K_NODATA : K_DONE, data: 16'h0000};
        end
        if (rx_valid)
            last_ff <= rx_frame;
    end
    // an idle link shows the inverse of the last frame, never a stale copy
    assign rx_valid = inj_valid | dly_ff[1];
    assign rx_frame = inj_valid ? inj_frame : (dly_ff[1] ? rep_ff : pntc_frame_t'(~last_ff));
endmodule // pntc_far_end

// *** test/testbench.sv ***
// randomised self-checking bench for the network control core
`timescale 1ns/1ps
module testbench;
    import pntc_pkg::*;
    // ==========================================================
    // stimulus signals and bookkeeping
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    pntc_cmd_t cmd = '0;
    logic inj_valid = 1'b0;
    pntc_frame_t inj_frame = '0;
    logic cmd_ready, rsp_valid, rsp_last, rx_valid, tx_valid, tx_bcast, dlv_valid, synced, hop_strobe;
    logic [15:0] rsp_data, dlv_data;
    pntc_frame_t rx_frame, tx_frame;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int ntx = 0;
    logic [31:0] seed = 32'h5D89FA67;
    logic [15:0] polls[$];                         // poll destinations in order
    logic [15:0] lst[4] = '{16'h0003, 16'h0007, 16'h000F, 16'h0000};
    logic [15:0] exp_p[6] = '{16'h0003, 16'h0007, 16'h000F, 16'h000F, 16'h000F, 16'h0003};
    always #2 mclk = ~mclk;
    pntc_core #(.HOP_LEN(20)) u_pntc_core (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last),
        .rx_valid(rx_valid), .rx_frame(rx_frame), .tx_valid(tx_valid), .tx_frame(tx_frame),
        .tx_bcast(tx_bcast), .dlv_valid(dlv_valid), .dlv_data(dlv_data), .synced(synced),
        .hop_strobe(hop_strobe));
    pntc_far_end u_pntc_far_end (.mclk(mclk), .tx_valid(tx_valid), .tx_frame(tx_frame),
        .inj_valid(inj_valid), .inj_frame(inj_frame), .rx_valid(rx_valid), .rx_frame(rx_frame));
    // ==========================================================
    // helpers
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one command; the edge is skipped first so cmd_valid never toggles twice in a step
    task automatic issue(input pntc_op_t op, input logic [12:0] sel, input logic [15:0] d);
        @(posedge mclk) #1;
        while (cmd_ready !== 1'b1)
            @(posedge mclk) #1;
        cmd_valid = 1'b1;
        cmd = '{op: op, sel: sel, data: d};
        @(posedge mclk) #1;
        cmd_valid = 1'b0;
    endtask
    task automatic rd(input pntc_op_t op, input logic [12:0] sel, input logic [15:0] exp);
        issue(op, sel, 16'h0000);
        check({rsp_valid, rsp_data}, {1'b1, exp});
    endtask
    task automatic inject(input pntc_kind_t k, input logic [15:0] nid, input logic [7:0] nt, input logic [15:0] da,
        input logic [15:0] d);
        @(posedge mclk) #1;
        inj_valid = 1'b1;
        inj_frame = '{src: 16'h0009, dst: da, net_id: nid, net_type: nt, kind: k, data: d};
        @(posedge mclk) #1;
        inj_valid = 1'b0;
    endtask
    // ==========================================================
    // link monitor and hang guard
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (tx_valid === 1'b1)
            ntx <= ntx + 1;
        if (tx_valid === 1'b1 && tx_frame.kind == K_POLL)
            polls.push_back(tx_frame.dst);
        if (cyc == 40000)
        begin
            err_count++;
            tally_and_finish();
        end
    end
    // ==========================================================
    // main sequence
    initial
    begin
        logic [15:0] r;
        logic [15:0] v;
        int b;
        int n;
        repeat (16) @(posedge mclk);
        #1 rst_n = 1'b1;
        rd(OP_RD_REG, SEL_RETRY, 16'h0005);
        rd(OP_RD_REG, SEL_SYNC_TO, 16'h0064);
        rd(OP_RD_REG, SEL_POLL_TO, 16'h000A);
        rd(OP_RD_REG, SEL_VARIANT, 16'h0002);
        rd(OP_LIST_RD, 13'h0000, 16'h0002);
        rd(OP_LIST_RD, 13'h1FFF, 16'h2001);
        issue(OP_WR_REG, SEL_RETRY, 16'h00FF);
        rd(OP_RD_REG, SEL_RETRY, 16'h00FE);
        // random entry round trip; the all-ones address must not land in the list
        v = 16'(xorshift() % 32'd65535);
        issue(OP_LIST_WR, 13'h0100, v);
        issue(OP_LIST_WR, 13'h0100, 16'hFFFF);
        rd(OP_LIST_RD, 13'h0100, v);
        issue(OP_LIST_DUMP, 13'h0000, 16'h0000);
        n = 0;
        while (rsp_last !== 1'b1 && n < 9000)
        begin
            if (rsp_valid === 1'b1)
                n++;
            @(posedge mclk) #1;
        end
        check(20'(n), 20'd8191);
        // broadcast send with a random repeat count, no polling running
        r = 16'(xorshift() % 32'd4);
        issue(OP_WR_REG, SEL_RETRY, r);
        issue(OP_WR_REG, SEL_DEST_ADDR, BCAST_ADDR);
        b = ntx;
        issue(OP_SEND, 13'h0000, v);
        check({tx_valid, tx_bcast, tx_frame.dst}, {2'b11, BCAST_ADDR});
        repeat (20 * (r + 2)) @(posedge mclk);
        #1 check(20'(ntx - b), 20'(r + 1));
        inject(K_DATA, 16'h0000, 8'h00, BCAST_ADDR, v);
        check({dlv_valid, dlv_data}, {1'b1, v});
        // sync follows only our own network, then times out
        issue(OP_WR_REG, SEL_SYNC_TO, 16'h0004);
        inject(K_SYNC, 16'h0005, 8'h00, BCAST_ADDR, 16'h0000);
        check(synced, 1'b0);
        inject(K_SYNC, 16'h0000, 8'h00, BCAST_ADDR, 16'h0000);
        check(synced, 1'b1);
        repeat (30) @(posedge mclk);
        #1 check(synced, 1'b1);
        // count hop strobes over 100 cycles while waiting for the timeout
        n = 0;
        repeat (100)
        begin
            @(posedge mclk) #1;
            n += int'(hop_strobe === 1'b1);
        end
        check(synced, 1'b0);
        check(20'(n), 20'd5);
        // master polling over a short list with a silent unit
        for (int i = 0; i < 4; i++)
            issue(OP_LIST_WR, 13'(i), lst[i]);
        issue(OP_WR_REG, SEL_POLL_TO, 16'h0003);
        issue(OP_WR_REG, SEL_OWN_ADDR, MASTER_ADDR);
        @(posedge mclk) #1 check(synced, 1'b1);
        polls.delete();
        issue(OP_WR_REG, SEL_GRANT, {8'h00, GRANT_TDMA});
        repeat (140) @(posedge mclk);
        #1;
        foreach (exp_p[i])
            check(polls[i], exp_p[i]);
        // relayed peer data: the master repeats it to all and keeps none of it
        issue(OP_WR_REG, SEL_GRANT, 16'h0000);
        issue(OP_WR_REG, SEL_RETRY, 16'h0000);
        issue(OP_WR_REG, SEL_NET_TYPE, {8'h00, TOPO_RELAY});
        inject(K_DATA, 16'h0000, TOPO_RELAY, 16'h0005, v);
        check(dlv_valid, 1'b0);
        @(posedge mclk) #1 check({tx_valid, tx_bcast, tx_frame.dst}, {2'b11, 16'h0005});
        tally_and_finish();
    end
endmodule // testbench
